// ===== hdl/stap_fifo.sv
// Purpose: buffer of boundary snapshots awaiting the user
// Assumes: depth is a power of two
// Notes:   a full buffer refuses pushes through in_ready
module stap_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	// carrier
	stap_fifo_if.fifo b
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0]  wr_reg;
	logic [AW:0]  rd_reg;

	wire full  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	wire empty = (wr_reg == rd_reg);
	wire do_wr = b.in_valid && !full;
	wire do_rd = b.out_ready && !empty;

	assign b.in_ready  = !full;
	assign b.out_valid = !empty;
	assign b.out_data  = mem[rd_reg[AW-1:0]];

	always_ff @(posedge b.clk) begin
		if (do_wr) begin
			mem[wr_reg[AW-1:0]] <= b.in_data;
		end
	end

	always_ff @(posedge b.clk) begin
		if (!b.rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_reg + (AW+1)'(do_wr);
			rd_reg <= rd_reg + (AW+1)'(do_rd);
		end
	end
endmodule : stap_fifo

// ===== hdl/stap_fifo_if.sv
// Purpose: valid/ready carrier between the port logic and its snapshot buffer
// Assumes: both sides on one clock
// Notes:   fifo modport is the buffer, user modport the port logic
interface stap_fifo_if #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n
);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;

	modport fifo (
		input  clk, rst_n, in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data
	);
	modport user (
		input  in_ready, out_valid, out_data,
		output in_valid, in_data, out_ready
	);
endinterface : stap_fifo_if

// ===== hdl/stap_pkg.sv
// Purpose: shared types of the test access port logic
// Assumes: constants come from stap_regs.svh
// Notes:   state order follows the usual sixteen-state diagram
`include "stap_regs.svh"

package stap_pkg;

	typedef logic [`STAP_IR_W-1:0] stap_ir_t;

	typedef enum logic [3:0] {
		ST_TLR,
		ST_RTI,
		ST_SEL_DR,
		ST_CAP_DR,
		ST_SH_DR,
		ST_EX1_DR,
		ST_PAU_DR,
		ST_EX2_DR,
		ST_UPD_DR,
		ST_SEL_IR,
		ST_CAP_IR,
		ST_SH_IR,
		ST_EX1_IR,
		ST_PAU_IR,
		ST_EX2_IR,
		ST_UPD_IR
	} stap_state_t;

endpackage : stap_pkg

// ===== hdl/stap_regs.svh
// Purpose: constants of the memory test access port instruction logic
// Assumes: three-bit instruction register, one-bit bypass, 32-bit identification
// Notes:   the identification value is arbitrary and neutral
`ifndef STAP_REGS_SVH
`define STAP_REGS_SVH

`define STAP_IR_W        3
`define STAP_IR_EXTEST   3'h0
`define STAP_IR_IDCODE   3'h1
`define STAP_IR_SAMPLEZ  3'h2
`define STAP_IR_SAMPLE   3'h4
`define STAP_IR_BYPASS   3'h7
`define STAP_IR_CAPTURE  3'h1
`define STAP_IR_RESET    3'h1
`define STAP_ID_W        32
// arbitrary neutral value, bit 0 set marks a present identification register
`define STAP_ID_CODE     32'h0ABC_D001
`define STAP_BSR_LEN     85
`define STAP_SNAP_DEPTH  32

`endif

// ===== hdl/stap_top.sv
// Purpose: test access port instruction logic of a pipelined memory
// Assumes: test clock far slower than CLOCK, sampled and edge-detected here
// Notes:   scan logic only observes the memory, apart from floating its outputs through MEM_OUT_FLOAT
//          reserved codes act as a one-bit bypass
//          a full snapshot buffer drops new records, SNAP_ACCEPT shows it
`include "stap_regs.svh"

module stap_top #(
	parameter int                   BSR_LEN = `STAP_BSR_LEN,
	parameter int                   DEPTH   = `STAP_SNAP_DEPTH,
	parameter logic [`STAP_ID_W-1:0] ID_CODE = `STAP_ID_CODE
) (
	// clock and reset
	input  wire logic               CLOCK,
	input  wire logic               NRST,
	// test access pins
	input  wire logic               TCK,
	input  wire logic               TMS,
	input  wire logic               TDI,
	output logic                    TDO,
	output logic                    TDO_OE_N,
	// memory pins: observed levels, output float control, active code
	input  wire logic [BSR_LEN-1:0] PIN_LEVELS,
	output logic                    MEM_OUT_FLOAT,
	output logic [`STAP_IR_W-1:0]   IR_ACTIVE,
	// snapshot stream
	output logic [BSR_LEN-1:0]      SNAP_DATA,
	output logic                    SNAP_VALID,
	input  wire logic               SNAP_READY,
	output logic                    SNAP_ACCEPT
);

	function automatic stap_pkg::stap_state_t stap_next(
		input stap_pkg::stap_state_t s,
		input logic                  m
	);
		stap_pkg::stap_state_t n;
		n = stap_pkg::ST_TLR;
		case (s)
			stap_pkg::ST_TLR:    n = m ? stap_pkg::ST_TLR    : stap_pkg::ST_RTI;
			stap_pkg::ST_RTI:    n = m ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
			stap_pkg::ST_SEL_DR: n = m ? stap_pkg::ST_SEL_IR : stap_pkg::ST_CAP_DR;
			stap_pkg::ST_CAP_DR: n = m ? stap_pkg::ST_EX1_DR : stap_pkg::ST_SH_DR;
			stap_pkg::ST_SH_DR:  n = m ? stap_pkg::ST_EX1_DR : stap_pkg::ST_SH_DR;
			stap_pkg::ST_EX1_DR: n = m ? stap_pkg::ST_UPD_DR : stap_pkg::ST_PAU_DR;
			stap_pkg::ST_PAU_DR: n = m ? stap_pkg::ST_EX2_DR : stap_pkg::ST_PAU_DR;
			stap_pkg::ST_EX2_DR: n = m ? stap_pkg::ST_UPD_DR : stap_pkg::ST_SH_DR;
			stap_pkg::ST_UPD_DR: n = m ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
			stap_pkg::ST_SEL_IR: n = m ? stap_pkg::ST_TLR    : stap_pkg::ST_CAP_IR;
			stap_pkg::ST_CAP_IR: n = m ? stap_pkg::ST_EX1_IR : stap_pkg::ST_SH_IR;
			stap_pkg::ST_SH_IR:  n = m ? stap_pkg::ST_EX1_IR : stap_pkg::ST_SH_IR;
			stap_pkg::ST_EX1_IR: n = m ? stap_pkg::ST_UPD_IR : stap_pkg::ST_PAU_IR;
			stap_pkg::ST_PAU_IR: n = m ? stap_pkg::ST_EX2_IR : stap_pkg::ST_PAU_IR;
			stap_pkg::ST_EX2_IR: n = m ? stap_pkg::ST_UPD_IR : stap_pkg::ST_SH_IR;
			stap_pkg::ST_UPD_IR: n = m ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
			default:             n = stap_pkg::ST_TLR;
		endcase
		return n;
	endfunction : stap_next

	// boundary chain users: all-zero, sample-with-float, sample/preload
	function automatic logic is_boundary(input stap_pkg::stap_ir_t ir);
		return (ir == `STAP_IR_EXTEST) || (ir == `STAP_IR_SAMPLEZ) ||
			(ir == `STAP_IR_SAMPLE);
	endfunction : is_boundary

	function automatic logic is_float(input stap_pkg::stap_ir_t ir);
		return (ir == `STAP_IR_EXTEST) || (ir == `STAP_IR_SAMPLEZ);
	endfunction : is_float

	// synchronisers, first stage read only by the second
	logic               tck_meta_reg;
	logic               tck_sync_reg;
	logic               tck_last_reg;
	logic               tms_meta_reg;
	logic               tms_sync_reg;
	logic               tdi_meta_reg;
	logic               tdi_sync_reg;
	logic [BSR_LEN-1:0] pin_meta_reg;
	logic [BSR_LEN-1:0] pin_sync_reg;

	// port state
	stap_pkg::stap_state_t state_reg;
	stap_pkg::stap_state_t state_next;
	stap_pkg::stap_ir_t    ir_reg;
	stap_pkg::stap_ir_t    ir_next;
	stap_pkg::stap_ir_t    irs_reg;
	stap_pkg::stap_ir_t    irs_next;
	logic [BSR_LEN-1:0]    bsr_reg;
	logic [BSR_LEN-1:0]    bsr_next;
	logic [`STAP_ID_W-1:0] id_reg;
	logic [`STAP_ID_W-1:0] id_next;
	logic                  byp_reg;
	logic                  byp_next;
	logic                  tdo_reg;
	logic                  tdo_next;
	logic                  oe_n_reg;
	logic                  oe_n_next;
	logic                  float_reg;

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			tck_meta_reg <= 1'b0;
			tck_sync_reg <= 1'b0;
			tck_last_reg <= 1'b0;
			tms_meta_reg <= 1'b1;
			tms_sync_reg <= 1'b1;
			tdi_meta_reg <= 1'b1;
			tdi_sync_reg <= 1'b1;
		end else begin
			tck_meta_reg <= TCK;
			tck_sync_reg <= tck_meta_reg;
			tck_last_reg <= tck_sync_reg;
			tms_meta_reg <= TMS;
			tms_sync_reg <= tms_meta_reg;
			tdi_meta_reg <= TDI;
			tdi_sync_reg <= tdi_meta_reg;
		end
	end

	// pin levels may be mid-transition, the snapshot is only as good as the pins
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= PIN_LEVELS;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// edge detection on the synchronised test clock
	wire tck_rise = tck_sync_reg && !tck_last_reg;
	wire tck_fall = !tck_sync_reg && tck_last_reg;

	// state decode
	wire in_tlr = (state_reg == stap_pkg::ST_TLR);
	wire cap_ir = tck_rise && (state_reg == stap_pkg::ST_CAP_IR);
	wire sh_ir  = (state_reg == stap_pkg::ST_SH_IR);
	wire upd_ir = tck_rise && (state_reg == stap_pkg::ST_UPD_IR);
	wire cap_dr = tck_rise && (state_reg == stap_pkg::ST_CAP_DR);
	wire sh_dr  = (state_reg == stap_pkg::ST_SH_DR);

	wire code_zero   = (ir_reg == `STAP_IR_EXTEST);
	wire code_ident  = (ir_reg == `STAP_IR_IDCODE);
	wire code_samplz = (ir_reg == `STAP_IR_SAMPLEZ);
	wire code_sample = (ir_reg == `STAP_IR_SAMPLE);
	wire code_bypass = (ir_reg == `STAP_IR_BYPASS);
	// reserved codes have no function, a one-bit path keeps the chain short
	wire code_resvd  = !(code_zero || code_ident || code_samplz || code_sample || code_bypass);

	// instruction decode, reserved codes fall back to the bypass path
	wire sel_bsr = is_boundary(ir_reg);
	wire sel_id  = code_ident;
	wire sel_byp = code_bypass || code_resvd;

	// per-register capture and shift strobes, one CLOCK cycle each
	wire ir_shift  = tck_rise && sh_ir;
	wire bsr_cap   = cap_dr && sel_bsr;
	wire bsr_shift = tck_rise && sh_dr && sel_bsr;
	wire id_cap    = cap_dr && sel_id;
	wire id_shift  = tck_rise && sh_dr && sel_id;
	wire byp_cap   = cap_dr && sel_byp;
	wire byp_shift = tck_rise && sh_dr && sel_byp;

	assign state_next = tck_rise ? stap_next(state_reg, tms_sync_reg) : state_reg;

	assign ir_next = in_tlr ? `STAP_IR_RESET : (upd_ir ? irs_reg : ir_reg);

	// in at MSB, out at LSB
	assign irs_next = cap_ir ? `STAP_IR_CAPTURE :
		(ir_shift ? {tdi_sync_reg, irs_reg[`STAP_IR_W-1:1]} : irs_reg);

	assign bsr_next = bsr_cap ? pin_sync_reg :
		(bsr_shift ? {tdi_sync_reg, bsr_reg[BSR_LEN-1:1]} : bsr_reg);

	assign id_next = id_cap ? ID_CODE :
		(id_shift ? {tdi_sync_reg, id_reg[`STAP_ID_W-1:1]} : id_reg);

	assign byp_next = byp_cap ? 1'b0 :
		(byp_shift ? tdi_sync_reg : byp_reg);

	// pin released outside shifts so a shared chain sees no contention
	wire in_shift = sh_ir || sh_dr;
	// serial output moves on the falling edge, driven only in shift states
	wire tdo_sel = sh_ir ? irs_reg[0] :
		(sel_bsr ? bsr_reg[0] : (sel_id ? id_reg[0] : byp_reg));
	assign tdo_next  = tck_fall ? tdo_sel : tdo_reg;
	assign oe_n_next = tck_fall ? !in_shift : oe_n_reg;

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			state_reg <= stap_pkg::ST_TLR;
			ir_reg    <= `STAP_IR_RESET;
			irs_reg   <= `STAP_IR_RESET;
		end else begin
			state_reg <= state_next;
			ir_reg    <= ir_next;
			irs_reg   <= irs_next;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			bsr_reg <= '0;
			id_reg  <= '0;
			byp_reg <= 1'b0;
		end else begin
			bsr_reg <= bsr_next;
			id_reg  <= id_next;
			byp_reg <= byp_next;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			tdo_reg  <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			tdo_reg  <= tdo_next;
			oe_n_reg <= oe_n_next;
		end
	end

	// registered so the memory's output drivers never see a decode glitch
	wire float_next = is_float(ir_reg);

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			float_reg <= 1'b0;
		end else begin
			float_reg <= float_next;
		end
	end

	// depth is a parameter, a slow reader loses only the newest records
	// snapshot stream, a full buffer drops the record and shows it on SNAP_ACCEPT
	stap_fifo_if #(.W(BSR_LEN)) snap (
		.clk   (CLOCK),
		.rst_n (NRST)
	);

	assign snap.in_valid  = bsr_cap;
	assign snap.in_data   = pin_sync_reg;
	assign snap.out_ready = SNAP_READY;

	stap_fifo #(
		.W (BSR_LEN),
		.D (DEPTH)
	) u_snap_fifo (
		.b (snap.fifo)
	);

	// outputs observe only, except MEM_OUT_FLOAT, which floats the memory's outputs
	assign MEM_OUT_FLOAT = float_reg;
	assign IR_ACTIVE     = ir_reg;
	assign TDO           = tdo_reg;
	assign TDO_OE_N      = oe_n_reg;
	assign SNAP_DATA     = snap.out_data;
	assign SNAP_VALID    = snap.out_valid;
	assign SNAP_ACCEPT   = snap.in_ready;

endmodule : stap_top

// ===== verif/stap_chk.sv
// Purpose: port checks of the test access logic
// Assumes: TCK far slower than CLOCK
// Notes:   link timing is judged only at the ports
`include "stap_regs.svh"
module stap_chk #(
	parameter int BSR_LEN = 85
) (
	// clock and reset
	input logic                  CLOCK,
	input logic                  NRST,
	// test pins
	input logic                  TCK,
	input logic                  TDO,
	input logic                  TDO_OE_N,
	// memory side
	input logic [BSR_LEN-1:0]    SNAP_DATA,
	input logic                  MEM_OUT_FLOAT,
	input logic [`STAP_IR_W-1:0] IR_ACTIVE,
	// snapshot stream
	input logic                  SNAP_VALID,
	input logic                  SNAP_READY,
	input logic                  SNAP_ACCEPT
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	a_reset_vals: assert property ($rose(NRST) |-> IR_ACTIVE == 3'h1 && TDO_OE_N)
		else $error("bad state after reset");
	a_float_code: assert property (1'b1 |=> MEM_OUT_FLOAT == ($past(IR_ACTIVE) inside {3'h0, 3'h2}))
		else $error("float does not follow code");
	a_ir_hold: assert property (!TDO_OE_N |=> $stable(IR_ACTIVE))
		else $error("instruction changed in shift");
	a_out_fall: assert property ($changed(TDO) || $changed(TDO_OE_N) |-> !TCK)
		else $error("serial out moved while TCK high");
	a_ir_rise: assert property ($changed(IR_ACTIVE) |-> TCK)
		else $error("instruction moved while TCK low");
	a_snap_hold: assert property (SNAP_VALID && !SNAP_READY |=> SNAP_VALID && $stable(SNAP_DATA))
		else $error("snapshot lost while stalled");
	a_snap_push: assert property ($rose(SNAP_VALID) |-> TCK && IR_ACTIVE inside {3'h0, 3'h2, 3'h4})
		else $error("snapshot under wrong code");
	a_full_nonempty: assert property (!SNAP_ACCEPT |-> SNAP_VALID)
		else $error("full buffer shows empty");
	cover property ($rose(SNAP_VALID));
	cover property ($fell(SNAP_ACCEPT));
	cover property ($fell(TDO_OE_N));
endmodule : stap_chk
bind stap_top stap_chk #(.BSR_LEN(BSR_LEN)) i_stap_chk (.CLOCK, .NRST, .TCK, .TDO, .TDO_OE_N,
	.SNAP_DATA, .MEM_OUT_FLOAT, .IR_ACTIVE, .SNAP_VALID, .SNAP_READY, .SNAP_ACCEPT);

// ===== verif/stap_ctrl.sv
// Purpose: board scan controller driving the test pins
// Assumes: 64 ns test clock, stopped between frames
// Notes:   data idles high like the pull-up, mode starts high but rests low after each walk
module stap_ctrl (
	// test pins
	output logic TCK,
	output logic TMS,
	output logic TDI,
	input  logic TDO,
	input  logic TDO_OE_N
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		TCK = 1'b0;
		TMS = 1'b1;
		TDI = 1'b1;
	end
	task automatic step(input logic ms, input logic di, output logic so);
		TMS = ms;
		TDI = di;
		#32 TCK = 1'b1;
		// released pin reads as the inverse, so a read outside shift fails
		so = TDO_OE_N ? !TDO : TDO;
		#32 TCK = 1'b0;
	endtask : step
	task automatic reset5();
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask : reset5
	// walk from idle; callers never pass a reserved code
	task automatic scan(input bit ir, input int n, input logic [127:0] din,
		output logic [127:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b1, o);
		if (ir) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		TDI = 1'b1;
	endtask : scan
endmodule : stap_ctrl

// ===== verif/stap_tb.sv
// Purpose: self-checking bench of the test access logic
// Assumes: all pins stable during capture
// Notes:   memory clock bits are not special here, pins never move during a capture
`include "stap_regs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        CLOCK = 1'b0;
	logic        NRST = 1'b0;
	logic        SNAP_READY = 1'b0;
	logic [84:0] PIN_LEVELS = '0;
	logic        TCK, TMS, TDI, TDO, TDO_OE_N, MEM_OUT_FLOAT, SNAP_VALID, SNAP_ACCEPT;
	logic [2:0]  IR_ACTIVE;
	logic [84:0] SNAP_DATA;
	logic [127:0] d;
	int          error_cnt = 0;
	int          samples_checked = 0;

	stap_top i_stap_top (.CLOCK, .NRST, .TCK, .TMS, .TDI, .TDO, .TDO_OE_N, .PIN_LEVELS,
		.MEM_OUT_FLOAT, .IR_ACTIVE, .SNAP_DATA, .SNAP_VALID, .SNAP_READY, .SNAP_ACCEPT);
	stap_ctrl i_stap_ctrl (.TCK, .TMS, .TDI, .TDO, .TDO_OE_N);

	always #2 CLOCK = ~CLOCK;

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic pop();
		@(posedge CLOCK) #1 SNAP_READY = 1'b1;
		@(posedge CLOCK) #1 SNAP_READY = 1'b0;
	endtask : pop
	task automatic load(input logic [2:0] c);
		i_stap_ctrl.scan(1'b1, 3, 128'(c), d);
		chk(d[2:0], 3'h1);
		repeat (3) @(posedge CLOCK);
		#1 chk(IR_ACTIVE, c);
	endtask : load
	task automatic t_reset();
		chk(IR_ACTIVE, 3'h1);
		chk({TDO_OE_N, MEM_OUT_FLOAT, SNAP_VALID, SNAP_ACCEPT}, 4'h9);
		i_stap_ctrl.reset5();
		$display("test reset done");
	endtask : t_reset
	// walks every non-reserved code, chain length worked out from the code
	task automatic t_codes();
		int len;
		logic [127:0] exp;
		for (int c = 0; c < 8; c++) begin
			// reserved codes are never issued, the port gives them no function
			if (c == 3 || c == 5 || c == 6) continue;
			PIN_LEVELS = 85'h1_2345_6789 ^ (85'(c) << 80); // pins still across capture
			load(3'(c));
			chk(MEM_OUT_FLOAT, c == 0 || c == 2);
			len = (c == 1) ? 32 : (c == 0 || c == 2 || c == 4) ? 85 : 1;
			exp = (c == 1) ? 128'(`STAP_ID_CODE) : (len == 85) ? 128'(PIN_LEVELS) : '0;
			exp[len +: 8] = 8'hA5;
			i_stap_ctrl.scan(1'b0, len + 8, 128'hA5, d);
			chk(d, exp);
			chk(SNAP_VALID, len == 85);
			if (len == 85) begin
				chk(128'(SNAP_DATA), 128'(PIN_LEVELS));
				pop();
			end
		end
		$display("test codes done");
	endtask : t_codes
	// fills the buffer past full with the reader stalled, then drains
	task automatic t_fifo();
		load(3'h4);
		for (int i = 0; i < 33; i++) begin
			PIN_LEVELS = (85'(i) << 50) | 85'(i);
			i_stap_ctrl.scan(1'b0, 1, '0, d);
		end
		chk({SNAP_ACCEPT, SNAP_VALID}, 2'h1);
		for (int i = 0; i < 32; i++) begin
			chk(128'(SNAP_DATA), 128'((85'(i) << 50) | 85'(i)));
			pop();
		end
		chk({SNAP_ACCEPT, SNAP_VALID}, 2'h2);
		$display("test buffer done");
	endtask : t_fifo
	// test reset from mid-shift must restore identification
	task automatic t_tapreset();
		logic o;
		load(3'h7);
		i_stap_ctrl.step(1'b1, 1'b1, o);
		repeat (3) i_stap_ctrl.step(1'b0, 1'b1, o);
		i_stap_ctrl.reset5();
		chk({IR_ACTIVE, TDO_OE_N}, 4'h3);
		$display("test tap reset done");
	endtask : t_tapreset
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		repeat (6) @(posedge CLOCK);
		#1 NRST = 1'b1;
		repeat (4) @(posedge CLOCK);
		#1 t_reset();
		t_codes();
		t_fifo();
		t_tapreset();
		stop_test();
	end
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
endmodule : testbench
